/* cams_asserts.sv */
// Purpose: Timing checks on the cascade link
// Assumes: Link clock domain only, one device end on the link
// Notes:   Sees the interface signals and the device reset only
module cams_asserts
(
    input wire logic       link_clk,
    input wire logic       dev_rst_n,
    input wire logic       cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [7:0] cmd_data,
    input wire logic       sdo_oe,
    input wire logic       casc_clk_oe,
    input wire logic       sync_a_lvl,
    input wire logic       sync_b_lvl
);
    // ============================================================
    // Properties
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!dev_rst_n);

    wire logic rd_cmd = cmd_valid && cmd_code == 3'h4;

    rd_cause_a: assert property (sdo_oe |-> $past(rd_cmd))
        else $error("sdo enabled without read");
    rd_single_a: assert property (sdo_oe |=> !sdo_oe)
        else $error("sdo enabled too long");
    out_idle_a: assert property (!sdo_oe && !rd_cmd |=> !sdo_oe)
        else $error("sdo enabled while idle");
    clk_stop_a:
        assert property (cmd_valid && cmd_code == 3'h5 && !cmd_data[0] |=> !casc_clk_oe)
        else $error("cascade clock kept after disable");
    clk_start_a:
        assert property ($rose(casc_clk_oe) |-> $past(cmd_valid) && $past(cmd_code) >= 3'h5)
        else $error("cascade clock started without command");
    cmd_gap_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command held too long");
    sync_short_a: assert property (!sync_a_lvl |=> sync_a_lvl[*8])
        else $error("sync pulse too long");
    sync_keep_a: assert property ($rose(sync_b_lvl) |=> sync_b_lvl[*8])
        else $error("sync line dropped after release");

    // ============================================================
    // Coverage
    cover property (sdo_oe);
    cover property (casc_clk_oe);
    cover property (!sync_a_lvl);
endmodule

/* cams_dev.sv */
// Purpose: Cascade device end: address match, memory gate, sync lines
// Assumes: All logic runs on the link clock; host changes commands
//          away from the rising edge of that clock
// Notes:   Display memory is one byte per word
//
// Chosen here: the APB interface to the registers and the address map.
`include "cams_map.svh"

module cams_dev
#(
    parameter int DEPTH     = `CAMS_MEM_DEPTH,
    parameter int FRAME_DIV = `CAMS_FRAME_DIV
)
(
    cams_if.dev              lnk,
    input  wire logic        dev_rst_n,
    input  wire logic        hw_id_pin_lsb,
    input  wire logic        hw_id_pin_msb,
    input  wire logic        oscillator_select_pin,
    input  wire logic [7:0]  status_in,
    input  wire logic [7:0]  temp_in,
    input  wire logic [5:0]  mem_raddr,
    output logic      [7:0]  mem_rdata,
    output logic             display_enable,
    output logic      [1:0]  bp_phase,
    output logic             sync_done,
    output logic             is_master
);

    localparam int PW = 6;
    localparam int FW = 8;

    // ============================================================
    // Storage
    logic [7:0]      mem_q [DEPTH];
    logic [1:0]      devaddr_r;
    logic [PW-1:0]   ptr_r;
    logic            disp_en_r;
    logic            coe_r;
    logic            rd_active_r;
    logic [7:0]      rd_data_r;
    logic [FW-1:0]   frame_cnt_r;
    logic [1:0]      phase_r;
    logic            synced_r;
    logic [7:0]      mem_rdata_r;

    // ============================================================
    // Decode
    logic [1:0]      hw_id;
    logic            match;
    logic            take_write;
    logic            take_ptr;
    logic            take_devaddr;
    logic            take_read;
    logic            take_disp;
    logic            take_coe;
    logic            mem_we;
    logic            frame_wrap;
    logic            sync_seen;
    logic [PW-1:0]   ptr_nxt;
    logic [FW-1:0]   frame_nxt;
    logic [1:0]      phase_nxt;

    function automatic logic is_cmd
    (
        input logic [2:0]       code,
        input cams_pkg::cams_cmd_e want
    );
        return code == want;
    endfunction

    function automatic logic [PW-1:0] ptr_step
    (
        input logic [PW-1:0] p
    );
        logic [PW-1:0] last;
        last = PW'(DEPTH - 1);
        return (p == last) ? '0 : p + PW'(1);
    endfunction

    assign hw_id        = {hw_id_pin_msb, hw_id_pin_lsb};
    assign is_master    = (hw_id == `CAMS_MASTER_ID);
    // Pins are read live; a change mid access would corrupt it
    assign match        = (devaddr_r == hw_id);

    assign take_write   = lnk.cmd_valid & is_cmd(lnk.cmd_code, cams_pkg::CAMS_CMD_WRITE);
    assign take_ptr     = lnk.cmd_valid & is_cmd(lnk.cmd_code, cams_pkg::CAMS_CMD_PTR);
    assign take_devaddr = lnk.cmd_valid & is_cmd(lnk.cmd_code, cams_pkg::CAMS_CMD_DEVADDR);
    assign take_read    = lnk.cmd_valid & is_cmd(lnk.cmd_code, cams_pkg::CAMS_CMD_READ);
    assign take_disp    = lnk.cmd_valid & is_cmd(lnk.cmd_code, cams_pkg::CAMS_CMD_DISP);
    assign take_coe     = lnk.cmd_valid & is_cmd(lnk.cmd_code, cams_pkg::CAMS_CMD_COE);

    assign mem_we       = take_write & match;
    // Pointer steps on every write so all devices stay in step
    assign ptr_nxt      = take_ptr   ? lnk.cmd_data[PW-1:0] :
                          take_write ? ptr_step(ptr_r) : ptr_r;

    // ============================================================
    // Frame timing and sync
    assign frame_wrap   = (frame_cnt_r == FW'(FRAME_DIV - 1));
    assign sync_seen    = ~lnk.sync_a_lvl;
    // Low on sync line restarts everyone at the same edge
    assign frame_nxt    = (sync_seen | frame_wrap) ? '0 : frame_cnt_r + FW'(1);
    assign phase_nxt    = sync_seen  ? 2'h0 :
                          frame_wrap ? phase_r + 2'h1 : phase_r;

    // Master pulls line a low for the last count of every fourth frame (phase 3)
    assign lnk.sync_a_o  = 1'b0;
    assign lnk.sync_a_oe = is_master & (frame_cnt_r == FW'(FRAME_DIV - 1)) &
                           (phase_r == 2'h3);
    // Line b held low until this device has seen a sync
    assign lnk.sync_b_o  = 1'b0;
    assign lnk.sync_b_oe = ~synced_r;

    // ============================================================
    // Cascade clock out
    // Any device on its own oscillator drives the clock once clock out and display are on
    assign lnk.casc_clk_o  = lnk.link_clk;
    assign lnk.casc_clk_oe = coe_r & disp_en_r & ~oscillator_select_pin;

    // ============================================================
    // Data output
    assign lnk.sdo_o  = rd_data_r;
    assign lnk.sdo_oe = rd_active_r & match;

    // ============================================================
    // User side
    assign mem_rdata      = mem_rdata_r;
    assign display_enable = disp_en_r;
    assign bp_phase       = phase_r;
    assign sync_done      = synced_r & lnk.sync_b_lvl;

    // ============================================================
    // Control registers
    always_ff @(posedge lnk.link_clk or negedge dev_rst_n)
    begin
        if (!dev_rst_n)
        begin
            devaddr_r <= `CAMS_RST_DEVADDR;
            ptr_r     <= '0;
            disp_en_r <= 1'b0;
            coe_r     <= 1'b0;
        end
        else
        begin
            ptr_r <= ptr_nxt;
            if (take_devaddr)
            begin
                devaddr_r <= lnk.cmd_data[1:0];
            end
            if (take_disp)
            begin
                disp_en_r <= lnk.cmd_data[0];
            end
            if (take_coe)
            begin
                coe_r <= lnk.cmd_data[0];
            end
        end
    end

    // ============================================================
    // Readout
    always_ff @(posedge lnk.link_clk or negedge dev_rst_n)
    begin
        if (!dev_rst_n)
        begin
            rd_active_r <= 1'b0;
            rd_data_r   <= 8'h00;
        end
        else
        begin
            // Readout armed only for the addressed device
            rd_active_r <= take_read & match;
            if (take_read & match)
            begin
                rd_data_r <= lnk.cmd_data[0] ? temp_in : status_in;
            end
        end
    end

    // ============================================================
    // Frame counter and sync state
    always_ff @(posedge lnk.link_clk or negedge dev_rst_n)
    begin
        if (!dev_rst_n)
        begin
            frame_cnt_r <= '0;
            phase_r     <= 2'h0;
            synced_r    <= 1'b0;
        end
        else
        begin
            frame_cnt_r <= frame_nxt;
            phase_r     <= phase_nxt;
            if (sync_seen)
            begin
                synced_r <= 1'b1;
            end
        end
    end

    // ============================================================
    // Display memory, no reset on the array
    always_ff @(posedge lnk.link_clk)
    begin
        if (mem_we)
        begin
            mem_q[ptr_r] <= lnk.cmd_data;
        end
    end

    always_ff @(posedge lnk.link_clk or negedge dev_rst_n)
    begin
        if (!dev_rst_n)
        begin
            mem_rdata_r <= 8'h00;
        end
        else if (32'(mem_raddr) < DEPTH)
        begin
            mem_rdata_r <= mem_q[mem_raddr];
        end
        else
        begin
            mem_rdata_r <= 8'h00;
        end
    end

endmodule

/* cams_host.sv */
// Purpose: Host end: APB registers, link clock divider, command sender
// Assumes: Link clock is made here, so link signals need no crossing
// Notes:   Commands change on the falling edge of the link clock
`include "cams_map.svh"

module cams_host
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    cams_if.host             lnk
);

    logic                    run_r;
    logic [7:0]              div_r;
    logic [7:0]              hcnt_r;
    logic                    lclk_r;
    logic                    pend_r;
    logic [2:0]              pcode_r;
    logic [7:0]              pdata_r;
    logic                    cvalid_r;
    logic [2:0]              ccode_r;
    logic [7:0]              cdata_r;
    logic                    rdv_r;
    logic [7:0]              rdd_r;
    cams_pkg::cams_hstate_e  st_r;

    logic                    acc;
    logic                    sel_ctrl;
    logic                    sel_cmd;
    logic                    sel_st;
    logic                    busy;
    logic                    toggle;
    logic                    fall;
    logic                    is_rd;

    // ============================================================
    // APB decode, zero wait states
    assign acc      = psel & penable;
    assign sel_ctrl = (paddr == `CAMS_OFF_CTRL);
    assign sel_cmd  = (paddr == `CAMS_OFF_CMD);
    assign sel_st   = (paddr == `CAMS_OFF_STATUS);
    assign pready   = 1'b1;
    assign pslverr  = acc & ~(sel_ctrl | sel_cmd | sel_st);
    assign busy     = pend_r | (st_r != cams_pkg::CAMS_H_IDLE);
    assign prdata   = sel_ctrl ? {16'h0000, div_r, 7'h00, run_r} :
                      sel_st   ? {16'h0000, rdd_r, 6'h00, rdv_r, busy} : 32'h0000_0000;

    // ============================================================
    // Link clock divider
    assign toggle       = run_r & (hcnt_r >= div_r - 8'h01);
    assign fall         = toggle & lclk_r;
    assign lnk.link_clk = lclk_r;
    assign lnk.cmd_valid = cvalid_r;
    assign lnk.cmd_code  = ccode_r;
    assign lnk.cmd_data  = cdata_r;
    assign is_rd        = (ccode_r == cams_pkg::CAMS_CMD_READ);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hcnt_r <= 8'h00;
            lclk_r <= 1'b0;
        end
        else if (toggle)
        begin
            hcnt_r <= 8'h00;
            lclk_r <= ~lclk_r;
        end
        else if (run_r)
        begin
            hcnt_r <= hcnt_r + 8'h01;
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_r   <= `CAMS_RST_RUN;
            div_r   <= `CAMS_RST_DIV;
            pend_r  <= 1'b0;
            pcode_r <= 3'h0;
            pdata_r <= 8'h00;
        end
        else
        begin
            if (acc & pwrite & sel_ctrl)
            begin
                run_r <= pwdata[`CAMS_CTRL_RUN_BIT];
                div_r <= (pwdata[`CAMS_CTRL_DIV_MSB:`CAMS_CTRL_DIV_LSB] == 8'h00) ? 8'h01 :
                         pwdata[`CAMS_CTRL_DIV_MSB:`CAMS_CTRL_DIV_LSB];
            end
            // Broadcast on one link edge reaches all devices at once
            if (acc & pwrite & sel_cmd & ~busy)
            begin
                pend_r  <= 1'b1;
                pcode_r <= pwdata[`CAMS_CMD_CODE_MSB:`CAMS_CMD_CODE_LSB];
                pdata_r <= pwdata[`CAMS_CMD_DATA_MSB:`CAMS_CMD_DATA_LSB];
            end
            else if (fall & (st_r == cams_pkg::CAMS_H_IDLE))
            begin
                pend_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // Command sender
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r     <= cams_pkg::CAMS_H_IDLE;
            cvalid_r <= 1'b0;
            ccode_r  <= 3'h0;
            cdata_r  <= 8'h00;
            rdv_r    <= 1'b0;
            rdd_r    <= 8'h00;
        end
        else
        begin
            if (acc & pwrite & sel_cmd & ~busy)
            begin
                rdv_r <= 1'b0;
            end
            case (st_r)
                cams_pkg::CAMS_H_IDLE:
                begin
                    if (fall & pend_r)
                    begin
                        cvalid_r <= 1'b1;
                        ccode_r  <= pcode_r;
                        cdata_r  <= pdata_r;
                        st_r     <= cams_pkg::CAMS_H_SEND;
                    end
                end
                cams_pkg::CAMS_H_SEND:
                begin
                    if (fall)
                    begin
                        cvalid_r <= 1'b0;
                        st_r     <= cams_pkg::CAMS_H_IDLE;
                        if (is_rd)
                        begin
                            rdv_r <= lnk.sdo_oe;
                            rdd_r <= lnk.sdo_oe ? lnk.sdo_o : 8'h00;
                        end
                    end
                end
                default:
                begin
                    st_r <= cams_pkg::CAMS_H_IDLE;
                end
            endcase
        end
    end

endmodule

/* cams_if.sv */
// Purpose: Link between the host controller and one cascade device
// Assumes: Sync lines are wired-AND with pull-up
// Notes:   Levels of the shared lines are resolved here
interface cams_if;
    logic            link_clk;
    logic            cmd_valid;
    logic [2:0]      cmd_code;
    logic [7:0]      cmd_data;
    logic [7:0]      sdo_o;
    logic            sdo_oe;
    logic            sync_a_o;
    logic            sync_a_oe;
    logic            sync_b_o;
    logic            sync_b_oe;
    logic            casc_clk_o;
    logic            casc_clk_oe;
    logic            sync_a_lvl;
    logic            sync_b_lvl;

    // Pulled up; any enabled low driver wins
    assign sync_a_lvl = ~(sync_a_oe & ~sync_a_o);
    assign sync_b_lvl = ~(sync_b_oe & ~sync_b_o);

    modport dev
    (
        input  link_clk, cmd_valid, cmd_code, cmd_data, sync_a_lvl, sync_b_lvl,
        output sdo_o, sdo_oe, sync_a_o, sync_a_oe, sync_b_o, sync_b_oe,
        output casc_clk_o, casc_clk_oe
    );

    modport host
    (
        output link_clk, cmd_valid, cmd_code, cmd_data,
        input  sdo_o, sdo_oe, casc_clk_o, casc_clk_oe, sync_b_lvl
    );
endinterface

/* cams_map.svh */
// Purpose: Constants of the cascade address match and sync block
// Assumes: Included by both ends
// Notes:   Register offsets are byte addresses on APB
//
// How it works
// - Two address pins give identity, zero is master
// - Master with internal clock drives cascade clock
// - Slaves with select high take master clock
// - Display disabled stops cascade clock output
// - Host sends display on/off to all together
// - External clock: every device gets same clock
// - Two wired sync lines align devices after reset
// - Second sync line open with external drive voltage
// - Display memory written only on address match
// - Mismatch suppresses write, pointer still advances
// - Status readout only on address match
// - Mismatch keeps data output in high impedance
// - Address pins stay stable during any access
// - Synced devices keep backplane phases aligned
`ifndef CAMS_MAP_SVH
`define CAMS_MAP_SVH

// ============================================================
// Host register offsets
`define CAMS_OFF_CTRL        12'h000
`define CAMS_OFF_CMD         12'h004
`define CAMS_OFF_STATUS      12'h008

// ============================================================
// Field positions
`define CAMS_CTRL_RUN_BIT    0
`define CAMS_CTRL_DIV_LSB    8
`define CAMS_CTRL_DIV_MSB    15
`define CAMS_CMD_DATA_LSB    0
`define CAMS_CMD_DATA_MSB    7
`define CAMS_CMD_CODE_LSB    8
`define CAMS_CMD_CODE_MSB    10
`define CAMS_ST_BUSY_BIT     0
`define CAMS_ST_RDV_BIT      1
`define CAMS_ST_RDD_LSB      8
`define CAMS_ST_RDD_MSB      15

// ============================================================
// Reset values and counts
`define CAMS_RST_RUN         1'b1
`define CAMS_RST_DIV         8'h02
`define CAMS_RST_DEVADDR     2'h0
`define CAMS_MASTER_ID       2'h0
`define CAMS_MEM_DEPTH       51
`define CAMS_FRAME_DIV       16

`endif

/* cams_pkg.sv */
// Purpose: Types shared by both ends of the cascade link
// Assumes: Nothing
// Notes:   Command codes travel on the link as three bits
package cams_pkg;

    typedef enum logic [2:0]
    {
        CAMS_CMD_NOP     = 3'h0,
        CAMS_CMD_WRITE   = 3'h1,
        CAMS_CMD_DEVADDR = 3'h2,
        CAMS_CMD_PTR     = 3'h3,
        CAMS_CMD_READ    = 3'h4,
        CAMS_CMD_DISP    = 3'h5,
        CAMS_CMD_COE     = 3'h6
    } cams_cmd_e;

    typedef enum logic [1:0]
    {
        CAMS_H_IDLE = 2'b01,
        CAMS_H_SEND = 2'b10
    } cams_hstate_e;

endpackage

/* cascade_address_match_sync_bench.sv */
// Purpose: Host and device ends joined, driven over APB
// Assumes: Pins change only between commands
// Notes:   Memory reads wait three link periods for the crossing
module cascade_address_match_sync_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        dev_rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        id_lsb = 1'b0;
    logic        id_msb = 1'b0;
    logic        osc_sel = 1'b0;
    logic [7:0]  st_in = 8'h00;
    logic [7:0]  tp_in = 8'h00;
    logic [5:0]  raddr = 6'h00;
    logic [7:0]  rdata;
    logic        disp_en;
    logic [1:0]  bp_phase;
    logic        sync_done;
    logic        is_master;
    int          error_cnt = 0;
    int          checks_done = 0;
    logic [31:0] rd_q;
    logic        rd_e;

    cams_if lnk (); // Line b stays wired: drive voltage made on chip
    always #20 pclk = ~pclk;

    cams_host cams_host_inst
    (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .lnk     (lnk)
    );
    cams_dev cams_dev_inst
    (
        .lnk                   (lnk), // Same link clock as every device
        .dev_rst_n             (dev_rst_n),
        .hw_id_pin_lsb         (id_lsb),
        .hw_id_pin_msb         (id_msb),
        .oscillator_select_pin (osc_sel),
        .status_in             (st_in),
        .temp_in               (tp_in),
        .mem_raddr             (raddr),
        .mem_rdata             (rdata),
        .display_enable        (disp_en),
        .bp_phase              (bp_phase),
        .sync_done             (sync_done),
        .is_master             (is_master)
    );
    cams_asserts cams_asserts_inst
    (
        .link_clk    (lnk.link_clk),
        .dev_rst_n   (dev_rst_n),
        .cmd_valid   (lnk.cmd_valid),
        .cmd_code    (lnk.cmd_code),
        .cmd_data    (lnk.cmd_data),
        .sdo_oe      (lnk.sdo_oe),
        .casc_clk_oe (lnk.casc_clk_oe),
        .sync_a_lvl  (lnk.sync_a_lvl),
        .sync_b_lvl  (lnk.sync_b_lvl)
    );

    // ============================================================
    // Shared tasks
    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rd_q = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            close_out();
        end
    endtask

    // Waits for the link to go idle; leaves the last status in rd_q
    task automatic send(input logic [2:0] code, input logic [7:0] data);
        int n;
        apb(1'b1, 12'h004, {21'h0, code, data});
        n = 0;
        do
        begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end
        while (rd_q[0] !== 1'b0 && n < 50);
        if (rd_q[0] !== 1'b0)
        begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic mem_is(input logic [5:0] a, input logic [7:0] exp);
        raddr <= a;
        repeat (12) @(posedge pclk);
        chk("mem", {24'h0, rdata}, {24'h0, exp});
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped err", {31'h0, rd_e}, 32'h1);
        chk("unmapped data", rd_q, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_0301);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", rd_q, 32'h0000_0301);
        apb(1'b1, 12'h000, 32'h0000_0201);
        chk("master", {31'h0, is_master}, 32'h1);
        chk("sdo idle", {31'h0, lnk.sdo_oe}, 32'h0);
    endtask

    task automatic t_sync();
        int n;
        n = 0;
        while (sync_done !== 1'b1 && n < 4000)
        begin
            @(posedge pclk);
            n++;
        end
        chk("synced", {31'h0, sync_done}, 32'h1);
        chk("sync line", {31'h0, lnk.sync_b_lvl}, 32'h1);
        chk("phase", {30'h0, bp_phase}, 32'h0);
        if (sync_done !== 1'b1)
        begin
            close_out();
        end
    endtask

    // Second write lands while busy and must be dropped
    task automatic t_store();
        send(3'h2, 8'h00);
        send(3'h3, 8'h0A);
        apb(1'b1, 12'h004, 32'h0000_01EE);
        send(3'h1, 8'hDD);
        send(3'h1, 8'h44);
        mem_is(6'h0A, 8'hEE);
        mem_is(6'h0B, 8'h44);
    endtask

    // Word 0 gets a known value first, so a stray store would show
    task automatic t_skip();
        send(3'h3, 8'h00);
        send(3'h1, 8'hEE);
        send(3'h3, 8'h32);
        send(3'h1, 8'h11);
        send(3'h2, 8'h03);
        send(3'h1, 8'hC3);
        send(3'h2, 8'h00);
        send(3'h1, 8'h77);
        mem_is(6'h32, 8'h11);
        mem_is(6'h00, 8'hEE);
        mem_is(6'h01, 8'h77);
    endtask

    task automatic t_read();
        st_in <= 8'h96;
        tp_in <= 8'h3E;
        send(3'h4, 8'h00);
        chk("status", {16'h0, rd_q[15:8], 6'h0, rd_q[1], 1'b0}, 32'h0000_9602);
        send(3'h4, 8'h01);
        chk("temp", {16'h0, rd_q[15:8], 6'h0, rd_q[1], 1'b0}, 32'h0000_3E02);
        send(3'h2, 8'h02);
        send(3'h4, 8'h00);
        chk("rdv off", {31'h0, rd_q[1]}, 32'h0);
        id_msb <= 1'b1;
        send(3'h4, 8'h01);
        chk("rdv id2", {31'h0, rd_q[1]}, 32'h1);
        chk("slave", {31'h0, is_master}, 32'h0);
        id_msb <= 1'b0;
        send(3'h2, 8'h00);
    endtask

    task automatic t_clock();
        send(3'h6, 8'h01);
        send(3'h5, 8'h01);
        chk("disp", {31'h0, disp_en}, 32'h1);
        chk("clk on", {31'h0, lnk.casc_clk_oe}, 32'h1);
        send(3'h5, 8'h00);
        chk("clk off", {31'h0, lnk.casc_clk_oe}, 32'h0);
        osc_sel <= 1'b1;
        send(3'h5, 8'h01);
        chk("clk slave", {31'h0, lnk.casc_clk_oe}, 32'h0);
        send(3'h5, 8'h00);
        osc_sel <= 1'b0;
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Odd count keeps the release off a rising link edge
        repeat (11) @(posedge pclk);
        dev_rst_n <= 1'b1;
        t_reset();
        t_sync();
        t_store();
        t_skip();
        t_read();
        t_clock();
        close_out();
    end
endmodule
